// >>> gpp_pkg.sv
/*
 * Constants, types and decode helpers for the general purpose I/O ports.
 * Assumes a 100 MHz system clock and a word-indexed Avalon-MM register bus.
 */
package gpp_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NPORT = 6;          // Five wide ports plus the narrow port
    localparam int NPIN = 44;          // Pins that exist
    localparam int NPAD = 48;          // Pins padded to whole bytes
    localparam int TEST_PIN = 8;       // Port 1 bit 0
    localparam logic [7:0] WIDE_MASK = 8'hFF;
    localparam logic [7:0] NARROW_MASK = 8'h0F;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************
    // Register indices (byte address is four times these)
    // ****************************************
    localparam logic [1:0] RG_DATA = 2'h0;   // Bank 0: output latch / pin levels
    localparam logic [1:0] RG_IE = 2'h1;     // Bank 0: pin interrupt enable
    localparam logic [1:0] RG_GSEL = 2'h2;   // Bank 0: bus route select
    localparam logic [1:0] RG_DM0 = 2'h0;    // Bank 1: drive select low bit
    localparam logic [1:0] RG_DM1 = 2'h1;    // Bank 1: drive select high bit
    localparam logic [1:0] RG_IM0 = 2'h2;    // Bank 1: interrupt mode low bit
    localparam logic [1:0] RG_IM1 = 2'h3;    // Bank 1: interrupt mode high bit
    localparam logic [6:0] STAT_BASE = 7'h18; // Bank 0: sticky pin event flags

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_KHZ = 100000;
    localparam int HOLD_MS = 16;
    localparam int POR_MS = 64;
    localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
    localparam int POR_CYC = POR_MS * CLK_KHZ;
    localparam int CNT_W = 23;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        DRV_RES_LOW = 2'b00,   // Resistive low, strong high
        DRV_STRONG = 2'b01,    // Strong both ways
        DRV_HIZ = 2'b10,       // High impedance
        DRV_RES_HIGH = 2'b11   // Strong low, resistive high
    } gpp_drive_type;

    typedef enum logic [1:0] {
        IM_RISE = 2'b00,
        IM_FALL = 2'b01,
        IM_CHANGE = 2'b10
    } gpp_imode_type;

    typedef enum logic [1:0] {
        HS_RUN = 2'b00,
        HS_EXT = 2'b01,
        HS_POR = 2'b10
    } gpp_hold_type;

    // Width mask of a port
    function automatic logic [7:0] port_mask(input int p);
        return (p == NPORT - 1) ? NARROW_MASK : WIDE_MASK;
    endfunction

    // Index of a per-port register
    function automatic logic [6:0] reg_idx(input logic bank, input int p, input logic [1:0] r);
        return {bank, 1'b0, p[2:0], r};
    endfunction
endpackage

// >>> gpp_hold_if.sv
/*
 * Signals between the port logic and its reset hold-off timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface gpp_hold_if;
    logic ext_rst;    // External reset level
    logic pin_hold;   // Test pin output held off
    logic cpu_hold;   // CPU held off after power-on
    modport ctrl(input ext_rst, output pin_hold, output cpu_hold);
    modport user(output ext_rst, input pin_hold, input cpu_hold);
endinterface

// >>> gpp_holdoff.sv
/*
 * Hold-off timer: test pin hold after external reset, CPU hold after power-on.
 * Assumes sys_rst is the power-on reset, synchronous to clk.
 */
`timescale 1ns/1ps
module gpp_holdoff #(
    parameter int HOLD_CYCLES = gpp_pkg::HOLD_CYC, // Test pin hold-off
    parameter int POR_CYCLES = gpp_pkg::POR_CYC    // CPU hold-off
) (
    input wire logic clk,   // System clock
    input wire logic sys_rst, // Power-on reset
    gpp_hold_if.ctrl hold   // Hold-off signals
);
    gpp_pkg::gpp_hold_type state; // Current phase
    logic [gpp_pkg::CNT_W-1:0] cnt; // Cycles spent in phase

    // ****************************************
    // Phase sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= gpp_pkg::HS_POR;
            cnt <= '0;
            hold.pin_hold <= 1'b0;
            hold.cpu_hold <= 1'b1;
        end else if (hold.ext_rst) begin
            // Restart the test pin hold-off while reset stands
            state <= gpp_pkg::HS_EXT;
            cnt <= '0;
            hold.pin_hold <= 1'b1;
            hold.cpu_hold <= 1'b0;
        end else begin
            case (state)
                gpp_pkg::HS_POR: begin
                    // No pin hold after power-on: CPU wait hides it
                    if (cnt == gpp_pkg::CNT_W'(POR_CYCLES - 1)) begin
                        state <= gpp_pkg::HS_RUN;
                        hold.cpu_hold <= 1'b0;
                    end
                    cnt <= cnt + 1'b1;
                end
                gpp_pkg::HS_EXT: begin
                    if (cnt == gpp_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
                        state <= gpp_pkg::HS_RUN;
                        hold.pin_hold <= 1'b0;
                    end
                    cnt <= cnt + 1'b1;
                end
                gpp_pkg::HS_RUN: begin
                    cnt <= '0;
                end
                default: begin
                    state <= gpp_pkg::HS_RUN;
                    hold.pin_hold <= 1'b0;
                    hold.cpu_hold <= 1'b0;
                end
            endcase
        end
    end

    AST_POR_HOLD: assert property (@(posedge clk) $past(sys_rst) && !hold.ext_rst |-> hold.cpu_hold && !hold.pin_hold)
        else $error("CPU hold-off missing after power-on");
endmodule

// >>> gpp_ports.sv
/*
 * General purpose I/O ports: five 8-bit ports and one 4-bit port behind
 * an Avalon-MM slave with waitrequest. Assumes pin inputs synchronous
 * only to the pads; they are resynchronised here.
 */
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps

//Operation
// - Five byte ports plus one nibble port
// - Every bit readable input and writable output
// - Direction set per bit independently
// - Each bit routable to global busses
// - Interrupt on rise, fall or change-since-read
// - Drive per level: strong, resistive, high-Z
// - Test pin not output 16 ms after external reset; power-on holds only the CPU, for 64 ms
// - Test pin forced low during hold-off
// - Latch writes kept, shown after hold-off
// - Test pin input always works
// - Test pin configuration writable during hold-off
// - CPU waits 64 ms after power-on; an external reset during the wait releases the CPU at once
// - Latch write drives; read returns pins
// - Per-pin interrupt enable, cleared at reset
// - Route bit: high-Z feeds input bus
// - Two drive bits with data select behaviour
module gpp_ports #(
    parameter int HOLD_CYCLES = gpp_pkg::HOLD_CYC, // Test pin hold-off cycles
    parameter int POR_CYCLES = gpp_pkg::POR_CYC    // CPU hold-off cycles
) (
    input wire logic clk,                     // System clock
    input wire logic sys_rst,                 // Power-on reset
    input wire logic external_reset_pin,      // External reset, high active
    input wire logic [6:0] avs_address,       // Register index
    input wire logic avs_read,                // Read request
    input wire logic avs_write,               // Write request
    input wire logic [3:0] avs_byteenable,    // Byte lanes
    input wire logic [31:0] avs_writedata,    // Write data
    output logic [31:0] avs_readdata,         // Read data
    output logic avs_waitrequest,             // Stall
    input wire logic [43:0] pin_in,           // Pad levels
    output logic [43:0] pin_out,              // Strong drive level
    output logic [43:0] pin_oe,               // Strong drive enable
    output logic [43:0] pin_pu,               // Pull-up enable
    output logic [43:0] pin_pd,               // Pull-down enable
    input wire logic [43:0] glob_out,         // Global output bus
    output logic [43:0] glob_in,              // Global input bus
    output logic irq,                         // Pin interrupt
    output logic cpu_hold                     // CPU held off
);
    localparam int NP = gpp_pkg::NPORT;

    // ****************************************
    // Declarations
    // ****************************************
    gpp_hold_if hold_bus();                 // Hold-off signals
    logic rst_all;                          // Any reset
    logic [7:0] dr [NP];                    // Output latches
    logic [7:0] ie [NP];                    // Interrupt enables
    logic [7:0] gs [NP];                    // Bus route selects
    logic [7:0] dm0 [NP];                   // Drive select low bits
    logic [7:0] dm1 [NP];                   // Drive select high bits
    logic [7:0] im0 [NP];                   // Interrupt mode low bits
    logic [7:0] im1 [NP];                   // Interrupt mode high bits
    logic [7:0] stat [NP];                  // Sticky pin events
    logic [43:0] sync1;                     // First synchroniser stage
    logic [43:0] sync2;                     // Synchronised levels
    logic [43:0] prev;                      // Levels one cycle back
    logic [gpp_pkg::NPAD-1:0] last_rd;      // Levels at last data read
    logic [gpp_pkg::NPAD-1:0] lvl_pad;      // Padded levels
    logic [gpp_pkg::NPAD-1:0] ev_pad;       // Padded pin events
    logic [3:0] next_drv [gpp_pkg::NPIN];   // {oe, out, pu, pd}
    logic [43:0] next_gin;                  // Next global input bus
    logic wr_acc;                           // Write takes effect
    logic rd_acc;                           // Read data is sampled
    logic [7:0] wd;                         // Write byte
    logic [7:0] next_rdata;                 // Read mux
    logic next_irq;                         // Any enabled event

    assign rst_all = sys_rst | external_reset_pin;
    assign hold_bus.ext_rst = external_reset_pin;
    assign cpu_hold = hold_bus.cpu_hold;
    assign lvl_pad = {4'h0, sync2};
    assign wr_acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    // Same edge that loads read data, so the change reference is what software saw
    assign rd_acc = avs_read && avs_waitrequest;
    assign wd = avs_writedata[7:0];

    gpp_holdoff #(.HOLD_CYCLES(HOLD_CYCLES), .POR_CYCLES(POR_CYCLES)) u_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .hold(hold_bus.ctrl)
    );

    // Pad driver for one drive code and data level
    function automatic logic [3:0] drive(input logic [1:0] mode, input logic d);
        case (mode)
            gpp_pkg::DRV_RES_LOW: drive = d ? 4'hC : 4'h1;
            gpp_pkg::DRV_STRONG: drive = d ? 4'hC : 4'h8;
            gpp_pkg::DRV_RES_HIGH: drive = d ? 4'h2 : 4'h8;
            default: drive = 4'h0;                           // High impedance
        endcase
    endfunction

    // ****************************************
    // Bus handshake: one wait cycle per access
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ****************************************
    // Pin synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        // Runs through reset: a reset value would fake an edge on a pin idling high
        sync1 <= pin_in;
        sync2 <= sync1;
        prev <= sync2;
    end

    // ****************************************
    // Per-pin drive, routing and event decode
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < gpp_pkg::NPIN; gi++) begin : g_pin
            localparam int P = gi / 8;
            localparam int B = gi % 8;
            logic [1:0] mode;   // Drive code
            logic [1:0] imode;  // Interrupt mode
            logic dval;         // Level to drive
            assign mode = {dm1[P][B], dm0[P][B]};
            assign imode = {im1[P][B], im0[P][B]};
            // Routed and not high-Z: follow global output line
            assign dval = (gs[P][B] && mode != gpp_pkg::DRV_HIZ) ? glob_out[gi] : dr[P][B];
            if (gi == gpp_pkg::TEST_PIN) begin : g_test
                // Latch kept, pin held strong low until hold-off ends
                assign next_drv[gi] = hold_bus.pin_hold ? 4'h8 : drive(mode, dval);
            end else begin : g_norm
                assign next_drv[gi] = drive(mode, dval);
            end
            assign next_gin[gi] = gs[P][B] && mode == gpp_pkg::DRV_HIZ && sync2[gi];
            always_comb begin
                case (imode)
                    gpp_pkg::IM_RISE: ev_pad[gi] = sync2[gi] && !prev[gi];
                    gpp_pkg::IM_FALL: ev_pad[gi] = !sync2[gi] && prev[gi];
                    default: ev_pad[gi] = sync2[gi] != last_rd[gi];
                endcase
            end
        end
        for (gi = gpp_pkg::NPIN; gi < gpp_pkg::NPAD; gi++) begin : g_pad
            assign ev_pad[gi] = 1'b0;
        end
    endgenerate

    // ****************************************
    // Pad and bus outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst_all) begin
            pin_oe <= '0;
            pin_out <= '0;
            pin_pu <= '0;
            pin_pd <= '0;
            glob_in <= '0;
        end else begin
            for (int i = 0; i < gpp_pkg::NPIN; i++) begin
                pin_oe[i] <= next_drv[i][3];
                pin_out[i] <= next_drv[i][2];
                pin_pu[i] <= next_drv[i][1];
                pin_pd[i] <= next_drv[i][0];
            end
            glob_in <= next_gin;
        end
    end

    // ****************************************
    // Per-port registers
    // ****************************************
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            localparam logic [7:0] PM = gpp_pkg::port_mask(gp);
            // Configuration and latch stores, writable any time outside reset
            always_ff @(posedge clk) begin
                if (rst_all) begin
                    dr[gp] <= gpp_pkg::RST_BYTE;
                    ie[gp] <= gpp_pkg::RST_BYTE;
                    gs[gp] <= gpp_pkg::RST_BYTE;
                    dm0[gp] <= gpp_pkg::RST_BYTE;
                    dm1[gp] <= gpp_pkg::RST_BYTE;
                    im0[gp] <= gpp_pkg::RST_BYTE;
                    im1[gp] <= gpp_pkg::RST_BYTE;
                end else if (wr_acc) begin
                    if (avs_address == gpp_pkg::reg_idx(1'b0, gp, gpp_pkg::RG_DATA)) begin
                        dr[gp] <= wd & PM;
                    end
                    if (avs_address == gpp_pkg::reg_idx(1'b0, gp, gpp_pkg::RG_IE)) begin
                        ie[gp] <= wd & PM;
                    end
                    if (avs_address == gpp_pkg::reg_idx(1'b0, gp, gpp_pkg::RG_GSEL)) begin
                        gs[gp] <= wd & PM;
                    end
                    if (avs_address == gpp_pkg::reg_idx(1'b1, gp, gpp_pkg::RG_DM0)) begin
                        dm0[gp] <= wd & PM;
                    end
                    if (avs_address == gpp_pkg::reg_idx(1'b1, gp, gpp_pkg::RG_DM1)) begin
                        dm1[gp] <= wd & PM;
                    end
                    if (avs_address == gpp_pkg::reg_idx(1'b1, gp, gpp_pkg::RG_IM0)) begin
                        im0[gp] <= wd & PM;
                    end
                    if (avs_address == gpp_pkg::reg_idx(1'b1, gp, gpp_pkg::RG_IM1)) begin
                        im1[gp] <= wd & PM;
                    end
                end
            end
            // Sticky events: a new event beats a same-cycle clear
            always_ff @(posedge clk) begin
                if (rst_all) begin
                    stat[gp] <= gpp_pkg::RST_BYTE;
                end else if (wr_acc && avs_address == gpp_pkg::STAT_BASE + 7'(gp)) begin
                    stat[gp] <= (stat[gp] & ~wd) | ev_pad[gp*8 +: 8];
                end else begin
                    stat[gp] <= stat[gp] | ev_pad[gp*8 +: 8];
                end
            end
            // Levels seen by the last data read, for change mode
            always_ff @(posedge clk) begin
                if (rst_all) begin
                    last_rd[gp*8 +: 8] <= gpp_pkg::RST_BYTE;
                end else if (rd_acc && avs_address == gpp_pkg::reg_idx(1'b0, gp, gpp_pkg::RG_DATA)) begin
                    last_rd[gp*8 +: 8] <= lvl_pad[gp*8 +: 8];
                end
            end
        end
    endgenerate

    // ****************************************
    // Read mux and interrupt
    // ****************************************
    always_comb begin
        next_rdata = 8'h00;
        next_irq = 1'b0;
        for (int p = 0; p < NP; p++) begin
            if (avs_address == gpp_pkg::reg_idx(1'b0, p, gpp_pkg::RG_DATA)) begin
                next_rdata = lvl_pad[p*8 +: 8];
            end
            if (avs_address == gpp_pkg::reg_idx(1'b0, p, gpp_pkg::RG_IE)) begin
                next_rdata = ie[p];
            end
            if (avs_address == gpp_pkg::reg_idx(1'b0, p, gpp_pkg::RG_GSEL)) begin
                next_rdata = gs[p];
            end
            if (avs_address == gpp_pkg::reg_idx(1'b1, p, gpp_pkg::RG_DM0)) begin
                next_rdata = dm0[p];
            end
            if (avs_address == gpp_pkg::reg_idx(1'b1, p, gpp_pkg::RG_DM1)) begin
                next_rdata = dm1[p];
            end
            if (avs_address == gpp_pkg::reg_idx(1'b1, p, gpp_pkg::RG_IM0)) begin
                next_rdata = im0[p];
            end
            if (avs_address == gpp_pkg::reg_idx(1'b1, p, gpp_pkg::RG_IM1)) begin
                next_rdata = im1[p];
            end
            if (avs_address == gpp_pkg::STAT_BASE + 7'(p)) begin
                next_rdata = stat[p];
            end
            next_irq = next_irq | (|(stat[p] & ie[p]));
        end
    end

    // Read data is loaded as waitrequest drops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h000000, next_rdata};
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_SYNC_TWO: assert property (@(posedge clk) disable iff (rst_all)
        !$past(rst_all, 2) && !$past(rst_all) |-> sync2[3] == $past(pin_in[3], 2))
        else $error("Pin level not synchronised in two cycles");
    AST_TEST_LOW: assert property (@(posedge clk) disable iff (rst_all)
        hold_bus.pin_hold |=> pin_oe[8] && !pin_out[8] && !pin_pu[8])
        else $error("Test pin not held low");
    AST_TEST_RELEASE: assert property (@(posedge clk) disable iff (rst_all)
        !hold_bus.pin_hold && !gs[1][0] && {dm1[1][0], dm0[1][0]} == 2'b01 |=> pin_out[8] == $past(dr[1][0]))
        else $error("Test pin latch not driven after hold-off");
    AST_IE_CLEAR: assert property (@(posedge clk)
        $past(rst_all) |-> ie[0] == 8'h00 && ie[5] == 8'h00 && !irq)
        else $error("Interrupt enables not cleared by reset");
    AST_RISE_FLAG: assert property (@(posedge clk) disable iff (rst_all)
        sync2[0] && !prev[0] && {im1[0][0], im0[0][0]} == 2'b00 |=> stat[0][0])
        else $error("Rising edge did not set event flag");
    AST_HIZ_FLOAT: assert property (@(posedge clk) disable iff (rst_all)
        {dm1[2][1], dm0[2][1]} == 2'b10 && !hold_bus.pin_hold |=> !pin_oe[17] && !pin_pu[17] && !pin_pd[17])
        else $error("High impedance pin still driven");
    AST_GLOB_IN: assert property (@(posedge clk) disable iff (rst_all)
        gs[3][2] && {dm1[3][2], dm0[3][2]} == 2'b10 |=> glob_in[26] == $past(sync2[26]))
        else $error("Global input line does not follow pin");
    AST_NARROW: assert property (@(posedge clk) disable iff (rst_all)
        dr[5][7:4] == 4'h0 && gs[5][7:4] == 4'h0)
        else $error("Narrow port holds bits above its width");
    AST_DATA_READ: assert property (@(posedge clk) disable iff (rst_all)
        avs_read && avs_waitrequest && avs_address == 7'h04 |=> avs_readdata[7:0] == $past(sync2[15:8]))
        else $error("Data read does not return pin levels");
endmodule

// >>> gpp_pad_model.sv
/*
 * Board pad model: settles each pin level from the block's drives.
 * Assumes the board drive beats pulls but not a strong driver.
 */
`timescale 1ns/1ps
module gpp_pad_model (
    input wire logic clk, // System clock
    input wire logic [43:0] pin_out, // Strong level
    input wire logic [43:0] pin_oe, // Strong enable
    input wire logic [43:0] pin_pu, // Pull-up enable
    input wire logic [43:0] pin_pd, // Pull-down enable
    input wire logic [43:0] board_val, // Board drive level
    input wire logic [43:0] board_en, // Board drive enable
    output logic [43:0] pin_in // Level at the pad
);
    // ****
    // Pad resolution
    // ****
    logic [43:0] wander = 44'h0; // Undriven pins toggle so no level is trusted
    always_ff @(posedge clk) begin
        wander <= ~wander;
    end
    // Strong drive wins, then board, then pulls
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & board_en & board_val)
            | (~pin_oe & ~board_en & (pin_pu | (~pin_pd & wander)));
    end
endmodule

// >>> gpp_ports_tb_top.sv
/*
 * Bench for the I/O ports; bus reads are checked from a queue of expectations.
 * Assumes short hold-off counts and the pad model on the pins.
 */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
$display("Error %s expected %h seen %h", what, exp, got); end end
module gpp_ports_tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, external_reset_pin = 1'b0; // Clock and resets
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq, cpu_hold; // Bus control
    logic [6:0] avs_address = 7'h00; // Register index
    logic [31:0] avs_writedata = 32'h0, avs_readdata, r, want, seed = 32'hDEE2; // Data, random
    logic [43:0] pin_in, pin_out, pin_oe, pin_pu, pin_pd, glob_in, glob_out = 44'h0; // Pins
    logic [47:0] board_val = 48'h0; // Board levels, padded to bytes
    logic [43:0] board_en = 44'hFFFFFFFFFFF; // Board drive enables
    logic [7:0] d, m0, m1, e, x; // Data, drive bits, board byte, expected
    logic [7:0] exp_q[$]; // Pending read expectations
    int num_errors = 0, comparisons = 0; // Tallies
    always #5 clk = ~clk;
    gpp_ports #(.HOLD_CYCLES(20), .POR_CYCLES(30)) u_gpp_ports (.clk(clk), .sys_rst(sys_rst),
        .external_reset_pin(external_reset_pin), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_pd(pin_pd), .glob_out(glob_out),
        .glob_in(glob_in), .irq(irq), .cpu_hold(cpu_hold));
    gpp_pad_model u_gpp_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .pin_pd(pin_pd), .board_val(board_val[43:0]), .board_en(board_en), .pin_in(pin_in));
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // One bus cycle, held until waitrequest is seen low
    task automatic acc(input logic rd, input logic [6:0] a, input logic [7:0] v);
        @(posedge clk);
        if (rd) exp_q.push_back(v);
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        avs_read <= rd;
        avs_write <= ~rd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("Errors %0d of %0d comparisons", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read data checked against the oldest expectation
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            want = {24'h0, exp_q.pop_front()};
            `CHK("readdata", want, avs_readdata)
        end
    end
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("cpu_hold", 1'b1, cpu_hold)
        acc(1'b1, 7'h01, 8'h00);
        acc(1'b1, 7'h3F, 8'h00);
        repeat (30) @(posedge clk);
        #1;
        `CHK("cpu_hold", 1'b0, cpu_hold)
        // Random per-bit drive modes against a driving board
        for (int p = 0; p < 6; p++) begin
            for (int i = 0; i < 4; i++) begin
                r = xorshift();
                {d, m0, m1, e} = r;
                board_val[8 * p +: 8] <= e;
                acc(1'b0, 7'h40 | 7'(4 * p), m0);
                acc(1'b0, 7'h41 | 7'(4 * p), m1);
                acc(1'b0, 7'(4 * p), d);
                repeat (6) @(posedge clk);
                x = (~m1 & ~m0 & (d | e)) | (~m1 & m0 & d) | (m1 & ~m0 & e) | (m1 & m0 & d & e);
                acc(1'b1, 7'(4 * p), x & (p == 5 ? 8'h0F : 8'hFF));
            end
        end
        // Resistive drives on port 0 with the board let go: pull-down, then pull-up
        board_en[7:0] <= 8'h00;
        for (int k = 0; k < 2; k++) begin
            acc(1'b0, 7'h40, {8{k[0]}});
            acc(1'b0, 7'h41, {8{k[0]}});
            acc(1'b0, 7'h00, {8{k[0]}});
            repeat (6) @(posedge clk);
            acc(1'b1, 7'h00, {8{k[0]}});
        end
        // Global bus routing on port 3
        r = xorshift();
        glob_out <= {r[11:0], r};
        acc(1'b0, 7'h0E, 8'hFF);
        acc(1'b0, 7'h4C, 8'hFF);
        acc(1'b0, 7'h4D, 8'h00);
        repeat (6) @(posedge clk);
        acc(1'b1, 7'h0C, r[31:24]);
        acc(1'b0, 7'h4C, 8'h00);
        acc(1'b0, 7'h4D, 8'hFF);
        repeat (6) @(posedge clk);
        #1;
        `CHK("glob_in", board_val[31:24], glob_in[31:24])
        // Pin events on port 4 bit 0: rise, fall, change since read
        acc(1'b0, 7'h50, 8'h00);
        acc(1'b0, 7'h51, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            acc(1'b0, 7'h52, {8{k[0]}});
            acc(1'b0, 7'h53, {8{k[1]}});
            acc(1'b0, 7'h11, k == 2 ? 8'h00 : 8'h01);
            board_val[32] <= (k == 1);
            repeat (6) @(posedge clk);
            acc(1'b1, 7'h10, {board_val[39:33], k == 1});
            acc(1'b0, 7'h1C, 8'hFF);
            acc(1'b1, 7'h1C, 8'h00);
            board_val[32] <= (k != 1);
            repeat (6) @(posedge clk);
            #1;
            `CHK("irq", k != 2, irq)
            acc(1'b1, 7'h1C, 8'h01);
            acc(1'b0, 7'h1C, 8'h01);
            acc(1'b1, 7'h1C, {7'h00, k == 2});
        end
        // Test pin hold-off after external reset
        external_reset_pin <= 1'b1;
        repeat (3) @(posedge clk);
        external_reset_pin <= 1'b0;
        acc(1'b0, 7'h44, 8'h01);
        acc(1'b0, 7'h04, 8'h01);
        acc(1'b0, 7'h05, 8'h01);
        #1;
        `CHK("hold oe", 1'b1, pin_oe[8])
        `CHK("hold out", 1'b0, pin_out[8])
        acc(1'b1, 7'h04, {board_val[15:9], 1'b0});
        repeat (25) @(posedge clk);
        #1;
        `CHK("released out", 1'b1, pin_out[8])
        acc(1'b1, 7'h05, 8'h01);
        tally_and_finish();
    end
endmodule
